// >>> shared/ept_pkg.sv
package ept_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALER_COUNT = 8'hD2;
    localparam logic [7:0] IDX_TIMER_COUNT = 8'hD3;
    localparam logic [7:0] IDX_TIMER_STATUS_CONTROL = 8'hD4;
    localparam logic [11:0] ADDR_PRESCALER_COUNT = {2'b00, IDX_PRESCALER_COUNT, 2'b00};
    localparam logic [11:0] ADDR_TIMER_COUNT = {2'b00, IDX_TIMER_COUNT, 2'b00};
    localparam logic [11:0] ADDR_TIMER_STATUS_CONTROL = {2'b00, IDX_TIMER_STATUS_CONTROL, 2'b00};

    // Reset values
    localparam logic [6:0] PRESCALER_RESET = 7'h7F;
    localparam logic [7:0] TIMER_COUNT_RESET = 8'hFF;
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_WRAP_VALUE = 8'hFF;
    localparam logic [7:0] TIMER_ZERO_VALUE = 8'h00;

    // Status and control field positions
    localparam int BIT_UNDERFLOW_FLAG = 7;
    localparam int BIT_UNDERFLOW_IRQ_ENABLE = 6;
    localparam int BIT_PIN_DIRECTION_SELECT = 5;
    localparam int BIT_OUTPUT_DATA = 4;
    localparam int BIT_PRESCALER_RUN = 3;
    localparam int BIT_DIVIDER_SELECT_HI = 2;
    localparam int BIT_DIVIDER_SELECT_LO = 0;
    localparam int PRESCALER_W = 7;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Bus channel states, one-hot
    typedef enum logic [1:0] {
        EPT_WR_IDLE = 2'b01,
        EPT_WR_RESP = 2'b10
    } ept_wr_state_t;

    typedef enum logic [1:0] {
        EPT_RD_IDLE = 2'b01,
        EPT_RD_DATA = 2'b10
    } ept_rd_state_t;

endpackage : ept_pkg

// >>> shared/ept_presc_if.sv
`timescale 1ns/100ps
// Link between the register block and the prescaler
interface ept_presc_if;
    logic run;
    logic [2:0] divider_select;
    logic load;
    logic [6:0] load_value;
    logic [6:0] count;
    logic tick;

    modport ctrl (output run, output divider_select, output load, output load_value,
        input count, input tick);
    modport presc (input run, input divider_select, input load, input load_value,
        output count, output tick);
endinterface : ept_presc_if

// >>> rtl/ept_prescaler.sv
`timescale 1ns/100ps
module ept_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    ept_presc_if.presc pif
);

    logic [6:0] count;
    logic [6:0] period_mask;

    // Mask of the low bits that must be zero for one period of 2^select
    assign period_mask = 7'((8'h01 << pif.divider_select) - 8'h01);

    // Prescaler counter: held at its start value while stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= ept_pkg::PRESCALER_RESET;
        end else if (!pif.run) begin
            count <= ept_pkg::PRESCALER_RESET;
        end else if (pif.load) begin
            count <= pif.load_value;
        end else begin
            count <= count - 7'h01;
        end
    end

    // One tick at the end of each selected period
    assign pif.tick = pif.run && ((count & period_mask) == 7'h00);
    assign pif.count = count;

endmodule : ept_prescaler

// >>> rtl/ept_timer.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// - Prescaler count register at index D2, read/write, resets to 7F.
// - Prescaler count holds seven bits; top bit always reads zero.
// - Timer count register at index D3, read/write, resets to FF.
// - Status and control register at index D4, read/write, resets to zero.
// - Underflow flag sets when timer count goes from 00 to FF.
// - Underflow flag stays set until software writes zero to it.
// - Interrupt request while enable bit and underflow flag are both one.
// - Direction bit zero makes the pin an input; one drives it push-pull.
// - Output mode drives data bit onto pin at underflow; input mode selects variant.
// - Run bit zero holds prescaler at 7F and stops all counting.
// - Run bit one lets the prescaler decrement every clock.
// - Divider select gives prescaler ratio of two to the field value.
// - In the wait state the timer keeps its clock and keeps counting.
// - An interrupt request ends the wait state.
// - Timer registers keep their contents across the wait state.
module ept_timer (
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pin, split into its three signals
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe,
    // Core power state and interrupt
    input wire logic core_wait_state,
    output logic timer_irq_req,
    output logic wait_wake_req
);

    // Prescaler sits behind a carrier interface
    ept_presc_if pif ();

    ept_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .pif(pif)
    );

    // Register state
    logic [7:0] timer_count;
    logic underflow_flag;
    logic underflow_irq_enable;
    logic pin_direction_select;
    logic output_data;
    logic prescaler_run;
    logic [2:0] divider_select;

    // Write channel state
    ept_pkg::ept_wr_state_t wr_state;
    logic aw_held;
    logic w_held;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // Read channel state
    ept_pkg::ept_rd_state_t rd_state;

    // Decoded write strobes
    logic wr_fire;
    logic wr_lane0;
    logic wr_mapped;
    logic wr_presc;
    logic wr_timer;
    logic wr_ctrl;

    // Counting chain
    logic count_gate;
    logic timer_step;
    logic underflow_event;
    logic [7:0] next_timer_count;
    logic [7:0] status_control;
    logic [31:0] next_rdata;
    logic rd_mapped;

    // ------------------------------------------------------------------
    // Write address and data are taken independently, in either order
    // ------------------------------------------------------------------

    // Ready while nothing of that kind is held and no response is pending
    assign s_axi_awready = !aw_held && (wr_state == ept_pkg::EPT_WR_IDLE);
    assign s_axi_wready = !w_held && (wr_state == ept_pkg::EPT_WR_IDLE);

    // Latch the write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            wr_addr <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Latch the write data and strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // The register write happens once both halves are held
    assign wr_fire = aw_held && w_held && (wr_state == ept_pkg::EPT_WR_IDLE);
    assign wr_lane0 = wr_fire && wr_strb[0];
    assign wr_mapped = (wr_addr == ept_pkg::ADDR_PRESCALER_COUNT)
        || (wr_addr == ept_pkg::ADDR_TIMER_COUNT)
        || (wr_addr == ept_pkg::ADDR_TIMER_STATUS_CONTROL);

    // Per-register strobes; only byte lane 0 carries register bits
    assign wr_presc = wr_lane0 && (wr_addr == ept_pkg::ADDR_PRESCALER_COUNT);
    assign wr_timer = wr_lane0 && (wr_addr == ept_pkg::ADDR_TIMER_COUNT);
    assign wr_ctrl = wr_lane0 && (wr_addr == ept_pkg::ADDR_TIMER_STATUS_CONTROL);

    // Write response state and answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= ept_pkg::EPT_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ept_pkg::RESP_OKAY;
        end else begin
            case (wr_state)
                ept_pkg::EPT_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state <= ept_pkg::EPT_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_mapped ? ept_pkg::RESP_OKAY : ept_pkg::RESP_SLVERR;
                    end
                end
                ept_pkg::EPT_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= ept_pkg::EPT_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state <= ept_pkg::EPT_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel: one read at a time, data registered one cycle later
    // ------------------------------------------------------------------

    // Address accepted only while no read answer waits
    assign s_axi_arready = (rd_state == ept_pkg::EPT_RD_IDLE);

    // Assemble the status and control byte
    assign status_control = {underflow_flag, underflow_irq_enable, pin_direction_select,
        output_data, prescaler_run, divider_select};

    // Read multiplexer; upper bits of every register read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            ept_pkg::ADDR_PRESCALER_COUNT: begin
                next_rdata = {25'h000_0000, pif.count};
            end
            ept_pkg::ADDR_TIMER_COUNT: begin
                next_rdata = {24'h00_0000, timer_count};
            end
            ept_pkg::ADDR_TIMER_STATUS_CONTROL: begin
                next_rdata = {24'h00_0000, status_control};
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // Read answer
    // Unmapped reads answer zero with an error response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= ept_pkg::EPT_RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ept_pkg::RESP_OKAY;
        end else begin
            case (rd_state)
                ept_pkg::EPT_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state <= ept_pkg::EPT_RD_DATA;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= next_rdata;
                        s_axi_rresp <= rd_mapped ? ept_pkg::RESP_OKAY : ept_pkg::RESP_SLVERR;
                    end
                end
                ept_pkg::EPT_RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state <= ept_pkg::EPT_RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    rd_state <= ept_pkg::EPT_RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------

    // Control bits; the wait state does not touch them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            underflow_irq_enable <=
                ept_pkg::STATUS_CONTROL_RESET[ept_pkg::BIT_UNDERFLOW_IRQ_ENABLE];
            pin_direction_select <=
                ept_pkg::STATUS_CONTROL_RESET[ept_pkg::BIT_PIN_DIRECTION_SELECT];
            output_data <= ept_pkg::STATUS_CONTROL_RESET[ept_pkg::BIT_OUTPUT_DATA];
            prescaler_run <= ept_pkg::STATUS_CONTROL_RESET[ept_pkg::BIT_PRESCALER_RUN];
            divider_select <= ept_pkg::STATUS_CONTROL_RESET[2:0];
        end else if (wr_ctrl) begin
            underflow_irq_enable <= wr_data[ept_pkg::BIT_UNDERFLOW_IRQ_ENABLE];
            pin_direction_select <= wr_data[ept_pkg::BIT_PIN_DIRECTION_SELECT];
            output_data <= wr_data[ept_pkg::BIT_OUTPUT_DATA];
            prescaler_run <= wr_data[ept_pkg::BIT_PRESCALER_RUN];
            divider_select <=
                wr_data[ept_pkg::BIT_DIVIDER_SELECT_HI:ept_pkg::BIT_DIVIDER_SELECT_LO];
        end
    end

    // Prescaler control over the carrier
    // A prescaler write only lands while running; stopped, it holds 7F
    assign pif.run = prescaler_run;
    assign pif.divider_select = divider_select;
    assign pif.load = wr_presc;
    assign pif.load_value = wr_data[6:0];

    // ------------------------------------------------------------------
    // Timer counter
    // ------------------------------------------------------------------

    // Input mode with data bit set: the pin gates counting
    // Output mode, or input mode with data bit clear, counts freely
    assign count_gate = pin_direction_select || !output_data || timer_pin_in;

    // One step per prescaler period while running; clock is never stopped
    assign timer_step = prescaler_run && pif.tick && count_gate;
    assign underflow_event = timer_step && (timer_count == ept_pkg::TIMER_ZERO_VALUE);

    // Next count: a software write wins, else decrement with wrap
    always_comb begin
        next_timer_count = timer_count;
        if (wr_timer) begin
            next_timer_count = wr_data[7:0];
        end else if (underflow_event) begin
            next_timer_count = ept_pkg::TIMER_WRAP_VALUE;
        end else if (timer_step) begin
            next_timer_count = timer_count - 8'h01;
        end
    end

    // Timer count register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count <= ept_pkg::TIMER_COUNT_RESET;
        end else begin
            timer_count <= next_timer_count;
        end
    end

    // Underflow flag: set wins over a software clear in the same cycle
    // Writing one to the flag leaves it alone; software cannot set it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            underflow_flag <= ept_pkg::STATUS_CONTROL_RESET[ept_pkg::BIT_UNDERFLOW_FLAG];
        end else if (underflow_event) begin
            underflow_flag <= 1'b1;
        end else if (wr_ctrl && !wr_data[ept_pkg::BIT_UNDERFLOW_FLAG]) begin
            underflow_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Timer pin
    // ------------------------------------------------------------------

    // Output level takes the data bit at each underflow
    // Level holds between underflows; underflows update it in input mode too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_pin_out <= 1'b0;
        end else if (underflow_event) begin
            timer_pin_out <= output_data;
        end
    end

    // Push-pull drive only in output mode
    assign timer_pin_oe = pin_direction_select;

    // ------------------------------------------------------------------
    // Interrupt and wake
    // ------------------------------------------------------------------

    // Level request; stands until the flag or the enable is cleared
    assign timer_irq_req = underflow_irq_enable && underflow_flag;

    // Wake only while the core is halted; counting never depends on it
    assign wait_wake_req = core_wait_state && timer_irq_req;

endmodule : ept_timer

// >>> tb/ept_pin_source.sv
`timescale 1ns/100ps
// Outside source on the timer pin
module ept_pin_source (
    input wire logic timer_pin_out,
    input wire logic timer_pin_oe,
    input wire logic gate_level,
    output logic timer_pin_in
);
    // Device drives the wire in output mode, the source otherwise
    assign timer_pin_in = timer_pin_oe ? timer_pin_out : gate_level;
endmodule : ept_pin_source

// >>> tb/ept_properties.sv
`timescale 1ns/100ps
// Bus handshake and pin relations at the top ports
module ept_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic timer_pin_oe,
    input wire logic timer_irq_req,
    input wire logic core_wait_state,
    input wire logic wait_wake_req
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Write steps: both halves taken, then the response
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_resp;
        ##[1:2] s_axi_bvalid;
    endsequence

    AST_WR_LAT: assert property (s_wr_taken |-> s_wr_resp)
        else $error("write response late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        $stable(s_axi_rdata) && s_axi_rvalid)
        else $error("read data dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_RDATA_TOP: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    AST_WAKE: assert property (wait_wake_req == (timer_irq_req && core_wait_state))
        else $error("wake request mismatch");
    AST_OE_CHANGE: assert property ($changed(timer_pin_oe) |-> $rose(s_axi_bvalid))
        else $error("pin direction changed without a write");
    AST_IRQ_FALL: assert property ($fell(timer_irq_req) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without a write");
endmodule : ept_properties

// >>> tb/eight_bit_prescaled_timer_tb.sv
`timescale 1ns/100ps
module eight_bit_prescaled_timer_tb;
    localparam logic [11:0] A_PS = ept_pkg::ADDR_PRESCALER_COUNT;
    localparam logic [11:0] A_TM = ept_pkg::ADDR_TIMER_COUNT;
    localparam logic [11:0] A_CT = ept_pkg::ADDR_TIMER_STATUS_CONTROL;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic timer_pin_in, timer_pin_out, timer_pin_oe, timer_irq_req, wait_wake_req;
    logic core_wait_state = 1'b0;
    logic gate_level = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    int c[2];

    // Clock
    always #5 aclk = ~aclk;

    ept_timer dut (.*);
    ept_pin_source pin (.timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
        .gate_level(gate_level), .timer_pin_in(timer_pin_in));

    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask : chk

    // Write: sample handshakes mid-cycle, release just after the taking edge
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ha, hw, hb;
        n = 0;
        hb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready === 1'b1;
            hw = s_axi_wvalid && s_axi_wready === 1'b1;
            hb = s_axi_bvalid === 1'b1;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            n++;
            if (n > 200) begin
                $display("[FAIL] bvalid_wait expected 1 seen 0");
                miscompares++;
                tally_and_finish();
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a);
        int n;
        logic ha, hr;
        n = 0;
        hr = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hr) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready === 1'b1;
            hr = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
            n++;
            if (n > 200) begin
                $display("[FAIL] rvalid_wait expected 1 seen 0");
                miscompares++;
                tally_and_finish();
            end
        end
    endtask : axi_read

    // Count settled cycles until the interrupt request shows
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        @(negedge aclk);
        while (timer_irq_req !== 1'b1 && cnt < lim) begin
            @(negedge aclk);
            cnt++;
        end
        if (timer_irq_req !== 1'b1) begin
            $display("[FAIL] irq_wait expected 1 seen 0");
            miscompares++;
            tally_and_finish();
        end
    endtask : wait_irq

    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(A_PS);
        chk("prescaler_reset", 32'h0000_007f, rd);
        axi_read(A_TM);
        chk("timer_reset", 32'h0000_00ff, rd);
        axi_read(A_CT);
        chk("control_reset", 32'h0000_0000, rd);
        axi_read(12'h010);
        chk("unmapped_resp", {30'h0, ept_pkg::RESP_SLVERR}, {30'h0, rsp});
        axi_write(12'h010, 32'h0000_00ff);
        chk("unmapped_wr_resp", {30'h0, ept_pkg::RESP_SLVERR}, {30'h0, rsp});
        axi_write(A_TM, 32'h0000_0005);
        chk("timer_wr_resp", {30'h0, ept_pkg::RESP_OKAY}, {30'h0, rsp});
        s_axi_wstrb <= 4'he;
        axi_write(A_TM, 32'h0000_0033);
        s_axi_wstrb <= 4'hf;
        repeat (20) @(posedge aclk);
        axi_read(A_TM);
        chk("timer_held", 32'h0000_0005, rd);
        axi_write(A_TM, 32'h0000_0000);
        axi_write(A_CT, 32'h0000_0008);
        repeat (4) @(negedge aclk);
        chk("irq_masked", 0, timer_irq_req);
        axi_write(A_CT, 32'h0000_0080);
        axi_read(A_CT);
        chk("flag_kept", 32'h0000_0080, rd);
        core_wait_state <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            for (int t = 0; t < 2; t++) begin
                axi_write(A_CT, 32'h0000_0000);
                axi_write(A_TM, t);
                axi_write(A_CT, 32'h48 | s);
                wait_irq(600, c[t]);
            end
            chk("divider_gap", 32'h1 << s, c[1] - c[0]);
        end
        axi_write(A_CT, 32'h0000_0000);
        axi_read(A_PS);
        chk("prescaler_stopped", 32'h0000_007f, rd);
        axi_write(A_TM, 32'h0000_0000);
        axi_write(A_CT, 32'h0000_0078);
        wait_irq(50, c[0]);
        chk("pin_level_high", 1, timer_pin_out);
        chk("pin_driven", 1, timer_pin_oe);
        chk("wake", 1, wait_wake_req);
        axi_read(A_CT);
        chk("flag_set", 32'h0000_00f8, rd);
        axi_write(A_CT, 32'h0000_0068);
        @(negedge aclk);
        chk("irq_cleared", 0, timer_irq_req);
        wait_irq(400, c[0]);
        chk("pin_level_low", 0, timer_pin_out);
        axi_write(A_PS, 32'h0000_00ff);
        axi_read(A_PS);
        chk("prescaler_top", 0, rd & 32'hffff_ff80);
        axi_write(A_CT, 32'h0000_0000);
        axi_write(A_TM, 32'h0000_0000);
        axi_write(A_CT, 32'h0000_0058);
        repeat (100) @(negedge aclk);
        chk("gate_closed", 0, timer_irq_req);
        axi_read(A_TM);
        chk("gate_count", 0, rd);
        chk("pin_input", 0, timer_pin_oe);
        @(posedge aclk);
        gate_level <= 1'b1;
        wait_irq(100, c[0]);
        chk("gate_open", 1, timer_irq_req);
        tally_and_finish();
    end
endmodule : eight_bit_prescaled_timer_tb

bind ept_timer ept_properties chk_i (.*);
